// File: design/fpgp_defs.svh
// constants for the four-pin port: offsets, field positions, reset values
// assumes a core that issues one register operation per instruction cycle
//
// Summary of operation
// - port reads return sampled pin levels, never the output latch
// - every pin is a high-impedance input after any reset
// - port register is eight bits; upper four read as zero
// - pin 3 never drives, whatever the direction bits hold
// - pull-ups and wake-on-change on pins 0,1,3, enabled by separate option bits
// - pin 3 as master clear: pull-up forced on, no wake-on-change
// - direction register loads from working register only on its instruction
// - direction one floats the pin; zero drives it from the latch
// - direction register write-only, all bits set by reset
// - fixed per-pin priority of clock, comparator, timer and direction
// - external driver holds input level until the read samples it
// - output latch holds until the port register is written again
// - pins 0 to 2 each have their own direction bit
// - status bit 7 set on pin-change wake reset, else cleared
// - status bit 6 set on comparator wake reset, else cleared
// - bit set/clear reads pins, modifies one bit, writes all latches
// - status at 03h, port at 06h; direction has no address
// - option bit 7 low enables wake, bit 6 low enables pull-ups
// - a driven pin loses pull-up and wake-on-change
// - writes commit at cycle end; pins sampled at cycle start
`ifndef FPGP_DEFS_SVH
`define FPGP_DEFS_SVH
`define FPGP_ADDR_STATUS   5'h03
`define FPGP_ADDR_PORT     5'h06
`define FPGP_STAT_PCWAKE   7
`define FPGP_STAT_CMPWAKE  6
`define FPGP_OPT_WAKEDIS   7
`define FPGP_OPT_PULLDIS   6
`define FPGP_OPT_TMRCLK    5
`define FPGP_PIN_OSC       2
`define FPGP_PIN_INONLY    3
`define FPGP_DIR_RESET     4'hf
`define FPGP_OPT_RESET     8'hff
`define FPGP_STAT_RESET    5'h18
`define FPGP_CLK_MHZ       100
`define FPGP_CYCLE_CLKS    4
`endif

// File: design/fpgp_pkg.sv
// types shared by the four-pin port
// assumes fpgp_defs.svh supplies the numeric constants
package fpgp_pkg;
	typedef enum logic [2:0] {
		OP_NONE, OP_READ, OP_WRITE, OP_BITSET, OP_BITCLR,
		OP_DIRLOAD, OP_OPTLOAD
	} fpgp_op_t;
	typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} fpgp_phase_t;
	typedef struct packed {
		fpgp_op_t   op;
		logic [4:0] addr;
		logic [7:0] data;
		logic [2:0] bitSel;
	} fpgp_req_t;
	typedef struct packed {
		logic cmpPosEn;
		logic cmpNegEn;
		logic cmpOutEn;
		logic cmpOutVal;
		logic oscQuarterEn;
		logic mclrEn;
	} fpgp_pinctl_t;
endpackage : fpgp_pkg

// File: design/fpgp_port.sv
// four-pin general i/o port with direction, option and wake-cause logic
// assumes the core holds its request through the first phase of a cycle
`include "fpgp_defs.svh"
module fpgp_port
	import fpgp_pkg::*;
#(
	parameter int PINS       = 4,
	parameter int CYCLE_CLKS = `FPGP_CYCLE_CLKS
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire fpgp_req_t    req,
	input  wire fpgp_pinctl_t pinCtl,
	input  wire logic         sleepMode,
	input  wire logic         pinWakeCause,
	input  wire logic         cmpWakeCause,
	input  wire logic [3:0]   pinIn,
	output logic [3:0]        pinOut,
	output logic [3:0]        pinOeN,
	output logic [3:0]        pullEn,
	output logic [3:0]        wakeEn,
	output logic              wakeReq,
	output logic              timerClock,
	output logic              cycleStart,
	output logic              rdValid,
	output logic [7:0]        rdData
);
	// ****************************************************
	// elaboration checks
	// ****************************************************
	if (PINS != 4 || CYCLE_CLKS != 4) begin : g_bad_param
		$error("fpgp_port needs four pins and a four-phase cycle");
	end

	// ****************************************************
	// decoding helpers
	// ****************************************************
	function automatic logic isPort(input logic [4:0] a);
		return a == `FPGP_ADDR_PORT;
	endfunction : isPort
	function automatic logic isStatus(input logic [4:0] a);
		return a == `FPGP_ADDR_STATUS;
	endfunction : isStatus
	function automatic logic [7:0] applyBit(
		input logic [7:0] v,
		input logic [2:0] s,
		input logic       setIt
	);
		logic [7:0] r;
		r    = v;
		r[s] = setIt;
		return r;
	endfunction : applyBit

	// ****************************************************
	// instruction cycle phases
	// ****************************************************
	fpgp_phase_t phase_r;
	fpgp_phase_t phase_nxt;
	logic        oscQ_r;

	always_comb begin
		case (phase_r)
			PH_Q1:   phase_nxt = PH_Q2;
			PH_Q2:   phase_nxt = PH_Q3;
			PH_Q3:   phase_nxt = PH_Q4;
			PH_Q4:   phase_nxt = PH_Q1;
			default: phase_nxt = PH_Q1;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			phase_r <= PH_Q1;
			oscQ_r  <= 1'b0;
		end else begin
			phase_r <= phase_nxt;
			// quarter-rate clock: high for the first half of a cycle
			oscQ_r  <= (phase_nxt == PH_Q1) || (phase_nxt == PH_Q2);
		end
	end

	wire logic atStart = (phase_r == PH_Q1);
	wire logic atEnd   = (phase_r == PH_Q4);

	// ****************************************************
	// request capture and pin sampling
	// ****************************************************
	fpgp_req_t  cur_r;
	logic [3:0] sample_r;
	logic [3:0] snap_r;

	// inputs are not latched between cycles; the driver must hold
	always_ff @(posedge clk) begin
		if (rst) begin
			cur_r    <= '{op: OP_NONE, addr: 5'h00, data: 8'h00,
				bitSel: 3'h0};
			sample_r <= 4'h0;
		end else if (atStart) begin
			cur_r    <= req;
			sample_r <= pinIn;
		end
	end

	// last port read is the reference for change detection
	always_ff @(posedge clk) begin
		if (rst)
			snap_r <= 4'h0;
		else if (atStart && req.op == OP_READ && isPort(req.addr))
			snap_r <= pinIn;
	end

	// ****************************************************
	// option and direction registers
	// ****************************************************
	logic [7:0] opt_r;
	logic [3:0] dir_r;

	// write-only, so no read path exists for either
	always_ff @(posedge clk) begin
		if (rst)
			dir_r <= `FPGP_DIR_RESET;
		else if (atEnd && cur_r.op == OP_DIRLOAD)
			dir_r <= cur_r.data[3:0];
	end

	always_ff @(posedge clk) begin
		if (rst)
			opt_r <= `FPGP_OPT_RESET;
		else if (atEnd && cur_r.op == OP_OPTLOAD)
			opt_r <= cur_r.data;
	end

	// ****************************************************
	// port latch and status
	// ****************************************************
	logic [3:0] latch_r;
	logic [4:0] stat_r;
	logic       pcWake_r;
	logic       cmpWake_r;
	logic [7:0] portRd;
	logic [7:0] statRd;
	logic       isBitOp;
	logic [7:0] portMod;
	logic [7:0] statMod;
	assign portRd  = {4'h0, sample_r};
	assign statRd  = {pcWake_r, cmpWake_r, 1'b0, stat_r};
	assign isBitOp = (cur_r.op == OP_BITSET) || (cur_r.op == OP_BITCLR);
	assign portMod = applyBit(portRd, cur_r.bitSel, cur_r.op == OP_BITSET);
	assign statMod = applyBit(statRd, cur_r.bitSel, cur_r.op == OP_BITSET);

	always_ff @(posedge clk) begin
		if (rst) begin
			latch_r <= 4'h0;
		end else if (atEnd && isPort(cur_r.addr)) begin
			// latch changes only on a port write or a port bit set/clear
			if (cur_r.op == OP_WRITE)
				latch_r <= cur_r.data[3:0];
			else if (isBitOp)
				// pins, not latches, feed the modify step
				latch_r <= portMod[3:0];
		end
	end

	// wake causes are caught while reset is held
	always_ff @(posedge clk) begin
		if (rst) begin
			stat_r    <= `FPGP_STAT_RESET;
			pcWake_r  <= pinWakeCause;
			cmpWake_r <= cmpWakeCause;
		end else if (atEnd && isStatus(cur_r.addr)) begin
			if (cur_r.op == OP_WRITE)
				stat_r <= cur_r.data[4:0];
			else if (isBitOp)
				stat_r <= statMod[4:0];
		end
	end

	// ****************************************************
	// read answer
	// ****************************************************
	logic rdIsPort_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			rdValid    <= 1'b0;
			rdData     <= 8'h00;
			rdIsPort_r <= 1'b0;
		end else begin
			rdValid    <= atStart && req.op == OP_READ;
			rdIsPort_r <= atStart && req.op == OP_READ
				&& isPort(req.addr);
			if (atStart && req.op == OP_READ) begin
				if (isPort(req.addr))
					rdData <= {4'h0, pinIn};
				else if (isStatus(req.addr))
					rdData <= statRd;
				else
					rdData <= 8'h00;
			end
		end
	end

	// ****************************************************
	// pin function priority
	// ****************************************************
	logic [3:0] oeN_nxt;
	logic [3:0] out_nxt;
	logic [3:0] pull_nxt;
	logic [3:0] wake_nxt;
	logic       pullOn;
	logic       wakeOn;

	assign pullOn = !opt_r[`FPGP_OPT_PULLDIS];
	assign wakeOn = !opt_r[`FPGP_OPT_WAKEDIS];

	always_comb begin
		out_nxt = latch_r;
		// analog comparator inputs float the pin first
		oeN_nxt[0] = pinCtl.cmpPosEn | dir_r[0];
		oeN_nxt[1] = pinCtl.cmpNegEn | dir_r[1];
		// pin 2: quarter clock, comparator, timer clock, direction
		if (pinCtl.oscQuarterEn) begin
			oeN_nxt[2] = 1'b0;
			out_nxt[2] = oscQ_r;
		end else if (pinCtl.cmpOutEn) begin
			oeN_nxt[2] = 1'b0;
			out_nxt[2] = pinCtl.cmpOutVal;
		end else if (opt_r[`FPGP_OPT_TMRCLK]) begin
			oeN_nxt[2] = 1'b1;
		end else begin
			oeN_nxt[2] = dir_r[2];
		end
		oeN_nxt[3] = 1'b1;
		out_nxt[3] = 1'b0;
		// shared enables; a driven pin loses both
		pull_nxt[0] = pullOn & dir_r[0] & !pinCtl.cmpPosEn;
		pull_nxt[1] = pullOn & dir_r[1] & !pinCtl.cmpNegEn;
		pull_nxt[2] = 1'b0;
		pull_nxt[3] = pinCtl.mclrEn | pullOn;
		wake_nxt[0] = wakeOn & dir_r[0] & !pinCtl.cmpPosEn;
		wake_nxt[1] = wakeOn & dir_r[1] & !pinCtl.cmpNegEn;
		wake_nxt[2] = 1'b0;
		wake_nxt[3] = wakeOn & !pinCtl.mclrEn;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pinOeN     <= 4'hf;
			pinOut     <= 4'h0;
			pullEn     <= 4'h0;
			wakeEn     <= 4'h0;
			timerClock <= 1'b0;
			cycleStart <= 1'b0;
		end else begin
			pinOeN     <= oeN_nxt;
			pinOut     <= out_nxt;
			pullEn     <= pull_nxt;
			wakeEn     <= wake_nxt;
			timerClock <= pinIn[`FPGP_PIN_OSC];
			cycleStart <= phase_nxt == PH_Q1;
		end
	end

	// ****************************************************
	// wake on change
	// ****************************************************
	logic [3:0] diff;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_diff
			assign diff[gi] = wakeEn[gi] & (pinIn[gi] ^ snap_r[gi]);
		end
	endgenerate

	// only meaningful asleep; a change while awake is ignored
	always_ff @(posedge clk) begin
		if (rst)
			wakeReq <= 1'b0;
		else
			wakeReq <= sleepMode & (|diff);
	end

	// ****************************************************
	// checks
	// ****************************************************
	sequence seqDirCommit;
		atEnd && cur_r.op == OP_DIRLOAD;
	endsequence
	sequence seqPortBitOp;
		atEnd && isPort(cur_r.addr) && isBitOp;
	endsequence
	chk_read_pins: assert property (@(posedge clk) disable iff (rst)
		rdIsPort_r |-> rdData[3:0] == $past(pinIn))
		else $error("port read did not return pin levels");
	chk_upper_zero: assert property (@(posedge clk) disable iff (rst)
		rdIsPort_r |-> rdData[7:4] == 4'h0)
		else $error("upper port bits not zero");
	chk_reset_float: assert property (@(posedge clk) disable iff (rst)
		$fell(rst) |-> pinOeN == 4'hf && dir_r == 4'hf)
		else $error("pins not floating after reset");
	chk_pin3_input: assert property (@(posedge clk) disable iff (rst)
		$changed(dir_r) |=> pinOeN[3])
		else $error("input-only pin driven");
	chk_dir_load: assert property (@(posedge clk) disable iff (rst)
		seqDirCommit |=> dir_r == $past(cur_r.data[3:0]))
		else $error("direction load lost");
	chk_dir_hold: assert property (@(posedge clk) disable iff (rst)
		!(atEnd && cur_r.op == OP_DIRLOAD) |=> $stable(dir_r))
		else $error("direction changed without its load");
	chk_latch_end: assert property (@(posedge clk) disable iff (rst)
		$changed(latch_r) |-> $past(atEnd) && $past(isPort(cur_r.addr)))
		else $error("latch changed outside a port write");
	chk_rmw_pins: assert property (@(posedge clk) disable iff (rst)
		seqPortBitOp |=> latch_r == $past(portMod[3:0]))
		else $error("bit operation did not use pin levels");
	chk_drive_dir: assert property (@(posedge clk) disable iff (rst)
		!pinCtl.cmpPosEn && !dir_r[0] |=> !pinOeN[0]
			&& pinOut[0] == $past(latch_r[0]))
		else $error("pin 0 not driven from latch");
	chk_osc_prio: assert property (@(posedge clk) disable iff (rst)
		pinCtl.oscQuarterEn |=> !pinOeN[2] && pinOut[2] == $past(oscQ_r))
		else $error("quarter clock not on pin 2");
	chk_pull_gate: assert property (@(posedge clk) disable iff (rst)
		!dir_r[1] |=> !pullEn[1] && !wakeEn[1])
		else $error("driven pin kept pull-up or wake");
	chk_master_clear_in_pull: assert property (@(posedge clk) disable iff (rst)
		pinCtl.mclrEn |=> pullEn[3] && !wakeEn[3])
		else $error("master clear pin pull or wake wrong");
	chk_wake_flags: assert property (@(posedge clk) disable iff (rst)
		$fell(rst) |-> pcWake_r == $past(pinWakeCause)
			&& cmpWake_r == $past(cmpWakeCause))
		else $error("wake cause flags wrong after reset");
	chk_phase_walk: assert property (@(posedge clk) disable iff (rst)
		atStart |=> phase_r == PH_Q2 ##1 phase_r == PH_Q3
			##1 atEnd ##1 atStart)
		else $error("instruction phases out of order");
endmodule : fpgp_port

// File: sim/fpgp_pin_ext.sv
// board wiring on the four port pins: outside driver, pull-up, floating
// assumes pinOeN is low while the port drives a pin
module fpgp_pin_ext (
	input  wire logic       clk,
	input  wire logic [3:0] pinOut,
	input  wire logic [3:0] pinOeN,
	input  wire logic [3:0] pullEn,
	input  wire logic [3:0] extEn,
	input  wire logic [3:0] extVal,
	output logic [3:0]      pinLvl
);
	timeunit 1ns;
	timeprecision 1ps;
	// a pin nobody holds drifts; toggle it so no stale level reads true
	logic [3:0] floatLvl_r = 4'h5;
	always @(posedge clk) begin
		floatLvl_r <= ~pinLvl;
	end
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			if (!pinOeN[i])
				pinLvl[i] = pinOut[i];
			else if (extEn[i])
				pinLvl[i] = extVal[i];
			else if (pullEn[i])
				pinLvl[i] = 1'b1;
			else
				pinLvl[i] = floatLvl_r[i];
		end
	end
endmodule : fpgp_pin_ext

// File: sim/testbench.sv
// self-checking bench for the four-pin port, one task per scenario
// assumes fpgp_pin_ext stands for the board on the pins
`include "fpgp_defs.svh"
module testbench import fpgp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic         clk, rst, sleepMode, pinWakeCause, cmpWakeCause;
	fpgp_req_t    req;
	fpgp_pinctl_t pinCtl;
	logic [3:0]   pinIn, pinOut, pinOeN, pullEn, wakeEn, extEn, extVal;
	logic         wakeReq, timerClock, cycleStart, rdValid;
	logic [7:0]   rdData;
	int           fails, checksDone, cycles, rdCount;

	fpgp_port uut (.clk(clk), .rst(rst), .req(req), .pinCtl(pinCtl),
		.sleepMode(sleepMode), .pinWakeCause(pinWakeCause),
		.cmpWakeCause(cmpWakeCause), .pinIn(pinIn), .pinOut(pinOut),
		.pinOeN(pinOeN), .pullEn(pullEn), .wakeEn(wakeEn),
		.wakeReq(wakeReq), .timerClock(timerClock),
		.cycleStart(cycleStart), .rdValid(rdValid), .rdData(rdData));
	fpgp_pin_ext board (.clk(clk), .pinOut(pinOut), .pinOeN(pinOeN),
		.pullEn(pullEn), .extEn(extEn), .extVal(extVal), .pinLvl(pinIn));

	always #5 clk = ~clk;
	always @(posedge clk) begin
		if (rdValid === 1'b1)
			rdCount++;
		cycles++;
		if (cycles == 20000) begin
			fails++;
			stop_test();
		end
	end

	task automatic chk(input string nm, input logic [7:0] seen, exp);
		checksDone++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// request held four clocks so exactly one phase-one edge takes it
	task automatic op(input fpgp_op_t o, input logic [4:0] a,
		input logic [7:0] d, input logic [2:0] b = 3'h0);
		@(posedge clk);
		req <= '{o, a, d, b};
		repeat (4) @(posedge clk);
		req <= '{OP_NONE, 5'h00, 8'h00, 3'h0};
		repeat (6) @(posedge clk);
		#1;
	endtask : op
	task automatic rd(input logic [4:0] a, input logic [7:0] exp);
		int n;
		n = rdCount;
		op(OP_READ, a, 8'h00);
		chk("rdData", rdData, exp);
		chk("rdValid count", 8'(rdCount - n), 8'h01);
	endtask : rd
	task automatic drive(input logic [3:0] en, v);
		@(posedge clk);
		extEn <= en;
		extVal <= v;
	endtask : drive
	task automatic setCtl(input fpgp_pinctl_t c);
		@(posedge clk);
		pinCtl <= c;
		repeat (3) @(posedge clk);
		#1;
	endtask : setCtl
	task automatic rstSeq(input logic pw, cw);
		@(posedge clk);
		rst <= 1'b1;
		pinWakeCause <= pw;
		cmpWakeCause <= cw;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask : rstSeq

	task automatic test_reset;
		int n;
		n = 0;
		chk("pinOeN", {4'h0, pinOeN}, 8'h0f);
		chk("pullEn", {4'h0, pullEn}, 8'h00);
		chk("wakeEn", {4'h0, wakeEn}, 8'h00);
		rd(5'h03, 8'h18);
		// one cycle start in every four clocks
		repeat (8) begin
			@(posedge clk);
			n += cycleStart;
		end
		chk("cycleStart", 8'(n), 8'h02);
		$display("test reset done");
	endtask : test_reset
	task automatic test_read;
		drive(4'hf, 4'ha);
		rd(5'h06, 8'h0a);
		rd(5'h05, 8'h00);
		op(OP_WRITE, 5'h06, 8'hf5);
		rd(5'h06, 8'h0a);
		chk("pinOeN", {4'h0, pinOeN}, 8'h0f);
		$display("test read done");
	endtask : test_read
	task automatic test_dir;
		// pin 2 floats under the timer-clock option, so hold it low
		drive(4'hc, 4'h8);
		op(OP_DIRLOAD, 5'h00, 8'hfe);
		chk("pinOeN", {4'h0, pinOeN}, 8'h0e);
		chk("pin0", {7'h00, pinOut[0]}, 8'h01);
		op(OP_DIRLOAD, 5'h00, 8'h00);
		chk("pinOeN", {4'h0, pinOeN}, 8'h0c);
		chk("pinOut", {5'h00, pinOut[2:0]}, 8'h05);
		op(OP_WRITE, 5'h06, 8'h02);
		chk("pinOut", {5'h00, pinOut[2:0]}, 8'h02);
		rd(5'h06, 8'h0a);
		$display("test dir done");
	endtask : test_dir
	task automatic test_rmw;
		op(OP_DIRLOAD, 5'h00, 8'h0f);
		drive(4'hf, 4'h3);
		op(OP_BITSET, 5'h06, 8'h00, 3'h2);
		drive(4'hc, 4'h4);
		op(OP_DIRLOAD, 5'h00, 8'h00);
		chk("pinOut", {5'h00, pinOut[2:0]}, 8'h07);
		op(OP_BITCLR, 5'h06, 8'h00, 3'h0);
		chk("pinOut", {5'h00, pinOut[2:0]}, 8'h06);
		$display("test rmw done");
	endtask : test_rmw
	task automatic test_option;
		op(OP_DIRLOAD, 5'h00, 8'h0f);
		drive(4'hf, 4'h0);
		op(OP_OPTLOAD, 5'h00, 8'h3f);
		chk("pullEn", {4'h0, pullEn}, 8'h0b);
		chk("wakeEn", {4'h0, wakeEn}, 8'h0b);
		rd(5'h06, 8'h00);
		@(posedge clk);
		sleepMode <= 1'b1;
		drive(4'hf, 4'h1);
		repeat (4) @(posedge clk);
		#1;
		chk("wakeReq", {7'h00, wakeReq}, 8'h01);
		@(posedge clk);
		sleepMode <= 1'b0;
		op(OP_DIRLOAD, 5'h00, 8'hfe);
		chk("wakeReq", {7'h00, wakeReq}, 8'h00);
		chk("pullEn", {4'h0, pullEn}, 8'h0a);
		chk("wakeEn", {4'h0, wakeEn}, 8'h0a);
		setCtl(6'b000001);
		chk("wakeEn", {4'h0, wakeEn}, 8'h02);
		op(OP_OPTLOAD, 5'h00, 8'hff);
		chk("pullEn", {4'h0, pullEn}, 8'h08);
		setCtl(6'b000000);
		$display("test option done");
	endtask : test_option
	task automatic test_prio;
		drive(4'hf, 4'h4);
		op(OP_DIRLOAD, 5'h00, 8'h0f);
		setCtl(6'b000010);
		chk("pinOeN", {4'h0, pinOeN}, 8'h0b);
		setCtl(6'b001100);
		chk("pinOut2", {7'h00, pinOut[2]}, 8'h01);
		chk("pinOeN", {4'h0, pinOeN}, 8'h0b);
		setCtl(6'b110000);
		op(OP_DIRLOAD, 5'h00, 8'h00);
		chk("pinOeN", {4'h0, pinOeN}, 8'h0f);
		chk("timerClock", {7'h00, timerClock}, 8'h01);
		setCtl(6'b000000);
		op(OP_OPTLOAD, 5'h00, 8'hdf);
		chk("pinOeN", {4'h0, pinOeN}, 8'h08);
		$display("test prio done");
	endtask : test_prio
	task automatic test_wake;
		rstSeq(1'b1, 1'b0);
		rd(5'h03, 8'h98);
		rstSeq(1'b0, 1'b1);
		rd(5'h03, 8'h58);
		op(OP_WRITE, 5'h03, 8'h3f);
		rd(5'h03, 8'h5f);
		rstSeq(1'b0, 1'b0);
		rd(5'h03, 8'h18);
		$display("test wake done");
	endtask : test_wake

	task automatic stop_test;
		$display("checks %0d mismatches %0d", checksDone, fails);
		if (fails == 0 && checksDone > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : stop_test

	initial begin
		clk = 1'b0;
		rst = 1'b1;
		req = '{OP_NONE, 5'h00, 8'h00, 3'h0};
		pinCtl = 6'b000000;
		sleepMode = 1'b0;
		pinWakeCause = 1'b0;
		cmpWakeCause = 1'b0;
		extEn = 4'h0;
		extVal = 4'h0;
		rstSeq(1'b0, 1'b0);
		test_reset();
		test_read();
		test_dir();
		test_rmw();
		test_option();
		test_prio();
		test_wake();
		stop_test();
	end
endmodule : testbench
